// ===== periodic_rate_and_trim_regs.sv
// Periodic rate and trim register bank with Avalon-MM slave
`timescale 1ns/1ps
module periodic_rate_and_trim_regs
  import periodic_trim_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Mode and lock inputs from the rest of the unit
  input wire logic i_special_mode,
  input wire logic i_protection_lock,
  input wire logic i_pll_clock_select,
  // Status set events from the clock generator
  input wire logic i_pll_lock_set,
  input wire logic i_osc_up_set,
  // Autonomous RC clock pin
  input wire logic i_aclk,
  // Flash trim load after reset release
  input wire logic i_trim_load,
  input wire logic [7:0] i_flash_temp_trim,
  input wire logic [15:0] i_flash_osc_trim,
  // Periodic timer
  output logic o_periodic_timeout_flag,
  // Temperature sense trim
  output logic o_temp_offset_enable,
  output logic [3:0] o_temp_sense_trim_bits,
  output logic [4:0] o_temp_threshold_steps,
  // Reference oscillator trim and factory test byte
  output logic [15:0] o_osc_trim_word,
  output logic [4:0] o_tempco_trim_bits,
  output logic o_tempco_comp_enable,
  output logic [3:0] o_coarse_trim,
  output logic [5:0] o_fine_trim,
  output logic [7:0] o_factory_test,
  // Clock status flags
  output logic o_pll_locked,
  output logic o_osc_up
);

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] readdata;
    logic clock_select;
    logic feature_enable;
    logic timeout_flag;
    logic [15:0] rate;
    logic [7:0] factory_test;
    logic [7:0] temp_trim;
    logic [15:0] osc_trim;
    logic pll_locked;
    logic osc_up;
  } regs_t;

  regs_t state;
  regs_t next_state;

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [9:0] index);
    return addr == {index, 2'b00};
  endfunction

  logic aclk_tick;
  logic timeout_pulse;

  pin_sync u_aclk_sync (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_pin(i_aclk),
    .o_rise(aclk_tick)
  );

  periodic_timer #(
    .RATE_W(16)
  ) u_timer (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_enable(state.feature_enable),
    .i_clock_select(state.clock_select),
    .i_rate(state.rate),
    .i_aclk_tick(aclk_tick),
    .o_timeout(timeout_pulse)
  );

  logic request;
  logic write_commit;
  logic [7:0] wbyte;
  logic osc_write;
  logic [7:0] read_byte;

  always_comb begin
    request = i_avs_read | i_avs_write;
    // One wait state: read data is captured in the first cycle and stands in the second; a write commits in the second
    write_commit = i_avs_write & state.ack & i_avs_byteenable[0];
    wbyte = i_avs_writedata[7:0];
    osc_write = 1'b0;
    read_byte = 8'h00;
    next_state = state;
    next_state.ack = request & ~state.ack;

    if (hit(i_avs_address, IDX_PERIODIC_CTRL)) begin
      read_byte = {state.clock_select, 4'h0, state.feature_enable, 1'b0, state.timeout_flag};
    end else if (hit(i_avs_address, IDX_RATE_HIGH)) begin
      read_byte = state.rate[15:8];
    end else if (hit(i_avs_address, IDX_RATE_LOW)) begin
      read_byte = state.rate[7:0];
    end else if (hit(i_avs_address, IDX_FACTORY_TEST)) begin
      read_byte = state.factory_test;
    end else if (hit(i_avs_address, IDX_TEMP_SENSE_TRIM)) begin
      read_byte = state.temp_trim & TEMP_TRIM_MASK;
    end else if (hit(i_avs_address, IDX_OSC_TRIM_HIGH)) begin
      read_byte = state.osc_trim[15:8] & OSC_TRIM_MASK[15:8];
    end else if (hit(i_avs_address, IDX_OSC_TRIM_LOW)) begin
      read_byte = state.osc_trim[7:0];
    end else if (hit(i_avs_address, IDX_CLOCK_STATUS)) begin
      read_byte = {6'h00, state.osc_up, state.pll_locked};
    end
    // Unmapped addresses read zero and ignore writes
    if (i_avs_read & ~state.ack) begin
      next_state.readdata = {24'h000000, read_byte};
    end

    // Sticky status flags: set wins over any clear in the same cycle
    if (timeout_pulse) begin
      next_state.timeout_flag = 1'b1;
    end

    if (write_commit) begin
      if (hit(i_avs_address, IDX_PERIODIC_CTRL)) begin
        // Clock select only changes while the feature stays disabled across the write
        if (!state.feature_enable && !wbyte[CTL_FEATURE_ENABLE_BIT]) begin
          next_state.clock_select = wbyte[CTL_CLOCK_SELECT_BIT];
        end
        next_state.feature_enable = wbyte[CTL_FEATURE_ENABLE_BIT];
        if (wbyte[CTL_TIMEOUT_FLAG_BIT] && !timeout_pulse) begin
          next_state.timeout_flag = 1'b0;
        end
      end
      if (hit(i_avs_address, IDX_RATE_HIGH) && !state.feature_enable) begin
        next_state.rate[15:8] = wbyte;
      end
      if (hit(i_avs_address, IDX_RATE_LOW) && !state.feature_enable) begin
        next_state.rate[7:0] = wbyte;
      end
      if (hit(i_avs_address, IDX_FACTORY_TEST) && i_special_mode) begin
        next_state.factory_test = wbyte;
      end
      if (hit(i_avs_address, IDX_TEMP_SENSE_TRIM)) begin
        next_state.temp_trim = wbyte & TEMP_TRIM_MASK;
      end
      if (hit(i_avs_address, IDX_OSC_TRIM_HIGH) && !i_protection_lock) begin
        next_state.osc_trim[15:8] = wbyte & OSC_TRIM_MASK[15:8];
        osc_write = 1'b1;
      end
      if (hit(i_avs_address, IDX_OSC_TRIM_LOW) && !i_protection_lock) begin
        next_state.osc_trim[7:0] = wbyte;
        osc_write = 1'b1;
      end
    end

    // Retrimming the reference under the PLL restarts lock and oscillator qualification
    if (osc_write && i_pll_clock_select) begin
      next_state.pll_locked = 1'b0;
      next_state.osc_up = 1'b0;
    end
    if (i_pll_lock_set) begin
      next_state.pll_locked = 1'b1;
    end
    if (i_osc_up_set) begin
      next_state.osc_up = 1'b1;
    end

    // Flash trim load after reset release overrides any bus write to the trim registers in the same cycle
    if (i_trim_load) begin
      next_state.temp_trim = i_flash_temp_trim & TEMP_TRIM_MASK;
      next_state.osc_trim = i_flash_osc_trim & OSC_TRIM_MASK;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= '0;
      state.factory_test <= RST_BYTE;
      state.temp_trim <= RST_BYTE;
      state.osc_trim <= RST_WORD;
      state.rate <= RST_WORD;
    end else begin
      state <= next_state;
    end
  end

  // Bus answer
  assign o_avs_waitrequest = request & ~state.ack;
  assign o_avs_readdata = state.readdata;

  assign o_periodic_timeout_flag = state.timeout_flag;
  assign o_factory_test = state.factory_test;

  // Temperature sense offset; trim bits are forced off when the offset is disabled
  assign o_temp_offset_enable = state.temp_trim[TEMP_OFFSET_ENABLE_BIT];
  assign o_temp_sense_trim_bits = o_temp_offset_enable ? state.temp_trim[TEMP_TRIM_MSB:0] : 4'h0;
  // Threshold rise in units of the lowest bit's step
  assign o_temp_threshold_steps = {1'b0, o_temp_sense_trim_bits};

  // Oscillator trim fields
  assign o_osc_trim_word = state.osc_trim & OSC_TRIM_MASK;
  assign o_tempco_trim_bits = state.osc_trim[TEMPCO_MSB:TEMPCO_LSB];
  assign o_tempco_comp_enable = (o_tempco_trim_bits != TEMPCO_NOMINAL_LOW)
    && (o_tempco_trim_bits != TEMPCO_NOMINAL_HIGH);
  assign o_coarse_trim = state.osc_trim[COARSE_MSB:COARSE_LSB];
  assign o_fine_trim = state.osc_trim[FINE_MSB:0];

  assign o_pll_locked = state.pll_locked;
  assign o_osc_up = state.osc_up;

endmodule // periodic_rate_and_trim_regs

// ===== periodic_rate_and_trim_regs_tb.sv
// Self-checking bench for the periodic rate and trim register bank
`timescale 1ns/1ps
module periodic_rate_and_trim_regs_tb
  import periodic_trim_pkg::*;
;
  logic i_clock = 1'b0, i_rstn = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0, i_special_mode = 1'b0;
  logic i_protection_lock = 1'b1, i_pll_clock_select = 1'b0, i_pll_lock_set = 1'b0, i_osc_up_set = 1'b0;
  logic i_aclk = 1'b0, i_trim_load = 1'b0, aclk_run = 1'b0, flag_q = 1'b0;
  logic [ADDR_W-1:0] i_avs_address = 12'h000;
  logic [DATA_W-1:0] i_avs_writedata = 32'h00000000, o_avs_readdata;
  logic [3:0] i_avs_byteenable = 4'hF, o_temp_sense_trim_bits, o_coarse_trim;
  logic [7:0] i_flash_temp_trim = 8'h00, rdv, o_factory_test;
  logic [15:0] i_flash_osc_trim = 16'h0000, o_osc_trim_word;
  logic o_avs_waitrequest, o_periodic_timeout_flag, o_temp_offset_enable, o_tempco_comp_enable;
  logic o_pll_locked, o_osc_up;
  logic [4:0] o_temp_threshold_steps, o_tempco_trim_bits;
  logic [5:0] o_fine_trim;
  int fail_count = 0, cmp_count = 0, cyc = 0, rise_a = 0, rise_b = 0, aclk_div = 0;
  periodic_rate_and_trim_regs dut (.*);
  always #50 i_clock = ~i_clock;
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Flag rise times; slow autonomous clock toggles every 3 bus clocks
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    flag_q <= o_periodic_timeout_flag;
    if (o_periodic_timeout_flag === 1'b1 && flag_q === 1'b0) begin
      rise_a <= rise_b;
      rise_b <= cyc;
    end
    if (aclk_run) begin
      aclk_div <= (aclk_div == 2) ? 0 : aclk_div + 1;
      if (aclk_div == 2) i_aclk <= ~i_aclk;
    end
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Holds the request until waitrequest is low at an edge; returns on the falling edge
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    @(posedge i_clock);
    i_avs_address <= {idx, 2'b00};
    i_avs_writedata <= {24'h000000, d};
    i_avs_write <= wr;
    i_avs_read <= !wr;
    @(negedge i_clock);
    while (o_avs_waitrequest !== 1'b0) @(negedge i_clock);
    @(posedge i_clock);
    rdv = o_avs_readdata[7:0];
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    @(negedge i_clock);
  endtask
  task automatic measure(input logic [7:0] ctl, input int exp_d);
    while (o_periodic_timeout_flag !== 1'b1) @(negedge i_clock);
    bus(1'b1, IDX_PERIODIC_CTRL, ctl);
    chk("flag after 0", 32'(o_periodic_timeout_flag), 32'h1);
    bus(1'b1, IDX_PERIODIC_CTRL, ctl | 8'h01);
    chk("flag after 1", 32'(o_periodic_timeout_flag), 32'h0);
    while (o_periodic_timeout_flag !== 1'b1) @(negedge i_clock);
    // The rise detector only records this rise at the next edge
    @(negedge i_clock);
    chk("period", 32'(rise_b - rise_a), 32'(exp_d));
  endtask
  initial begin
    repeat (20) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    i_flash_temp_trim <= 8'hFA;
    i_flash_osc_trim <= 16'h87FF;
    i_trim_load <= 1'b1;
    @(posedge i_clock);
    i_trim_load <= 1'b0;
    @(negedge i_clock);
    chk("osc word", 32'(o_osc_trim_word), 32'h83FF);
    chk("tempco", 32'(o_tempco_trim_bits), 32'h10);
    chk("comp", 32'(o_tempco_comp_enable), 32'h0);
    chk("coarse fine", 32'({o_coarse_trim, o_fine_trim}), 32'h3FF);
    chk("temp steps", 32'({o_temp_offset_enable, o_temp_threshold_steps}), 32'h2A);
    bus(1'b0, IDX_TEMP_SENSE_TRIM, 8'h00);
    chk("temp read", 32'(rdv), 32'h8A);
    bus(1'b1, IDX_TEMP_SENSE_TRIM, 8'h75);
    bus(1'b0, IDX_TEMP_SENSE_TRIM, 8'h00);
    chk("temp write", 32'(rdv), 32'h05);
    chk("gated bits", 32'({o_temp_offset_enable, o_temp_sense_trim_bits}), 32'h00);
    bus(1'b1, IDX_FACTORY_TEST, 8'h5A);
    bus(1'b0, IDX_FACTORY_TEST, 8'h00);
    chk("test normal", 32'(rdv), 32'h00);
    @(posedge i_clock);
    i_special_mode <= 1'b1;
    bus(1'b1, IDX_FACTORY_TEST, 8'h5A);
    bus(1'b0, IDX_FACTORY_TEST, 8'h00);
    chk("test special", 32'(rdv), 32'h5A);
    chk("test port", 32'(o_factory_test), 32'h5A);
    bus(1'b1, IDX_OSC_TRIM_LOW, 8'h00);
    chk("locked word", 32'(o_osc_trim_word), 32'h83FF);
    @(posedge i_clock);
    i_pll_lock_set <= 1'b1;
    i_osc_up_set <= 1'b1;
    i_protection_lock <= 1'b0;
    @(posedge i_clock);
    i_pll_lock_set <= 1'b0;
    i_osc_up_set <= 1'b0;
    bus(1'b1, IDX_OSC_TRIM_HIGH, 8'h2C);
    chk("word high", 32'(o_osc_trim_word), 32'h28FF);
    chk("flags kept", 32'({o_pll_locked, o_osc_up}), 32'h3);
    chk("comp on", 32'(o_tempco_comp_enable), 32'h1);
    @(posedge i_clock);
    i_pll_clock_select <= 1'b1;
    bus(1'b1, IDX_OSC_TRIM_LOW, 8'h41);
    chk("word low", 32'(o_osc_trim_word), 32'h2841);
    bus(1'b0, IDX_CLOCK_STATUS, 8'h00);
    chk("flags cleared", 32'(rdv), 32'h00);
    bus(1'b1, IDX_RATE_HIGH, 8'h00);
    bus(1'b1, IDX_RATE_LOW, 8'h05);
    bus(1'b1, IDX_PERIODIC_CTRL, 8'h80);
    bus(1'b1, IDX_PERIODIC_CTRL, 8'h84);
    measure(8'h84, 12);
    bus(1'b1, IDX_RATE_LOW, 8'h00);
    bus(1'b0, IDX_RATE_LOW, 8'h00);
    chk("rate locked", 32'(rdv), 32'h05);
    bus(1'b1, IDX_PERIODIC_CTRL, 8'h81);
    bus(1'b1, IDX_PERIODIC_CTRL, 8'h01);
    bus(1'b1, IDX_RATE_LOW, 8'h00);
    aclk_run = 1'b1;
    bus(1'b1, IDX_PERIODIC_CTRL, 8'h04);
    measure(8'h04, 24);
    close_out();
  end
endmodule // periodic_rate_and_trim_regs_tb

// ===== periodic_timer.sv
// Periodic time-out counter on the bus clock or on autonomous clock ticks
`timescale 1ns/1ps
module periodic_timer
  import periodic_trim_pkg::*;
#(
  parameter int RATE_W = 16
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_enable,
  input wire logic i_clock_select,
  input wire logic [RATE_W-1:0] i_rate,
  input wire logic i_aclk_tick,
  output logic o_timeout
);

  localparam int CNT_W = RATE_W + 2;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic timeout;
  } timer_t;

  timer_t state;
  timer_t next_state;

  // Last count value of one period: (rate+1)*ticks_per_step - 1
  function automatic logic [CNT_W-1:0] last_count(input logic sel, input logic [RATE_W-1:0] rate);
    logic [CNT_W:0] steps;
    logic [CNT_W:0] ticks;
    steps = (CNT_W+1)'(rate) + (CNT_W+1)'(1);
    ticks = steps * (sel ? (CNT_W+1)'(BUS_TICKS_PER_STEP) : (CNT_W+1)'(ACLK_TICKS_PER_STEP));
    return CNT_W'(ticks - (CNT_W+1)'(1));
  endfunction

  logic tick;

  always_comb begin
    tick = i_clock_select | i_aclk_tick;
    next_state = state;
    next_state.timeout = 1'b0;
    if (!i_enable) begin
      next_state.count = '0;
    end else if (tick) begin
      if (state.count == last_count(i_clock_select, i_rate)) begin
        next_state.count = '0;
        next_state.timeout = 1'b1;
      end else begin
        next_state.count = state.count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_timeout = state.timeout;

endmodule // periodic_timer

// ===== periodic_trim_chk.sv
// Concurrent checks on the ports of the periodic rate and trim register bank
`timescale 1ns/1ps
module periodic_trim_chk
  import periodic_trim_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic o_avs_waitrequest,
  input wire logic i_protection_lock,
  input wire logic i_pll_clock_select,
  input wire logic i_pll_lock_set,
  input wire logic i_osc_up_set,
  input wire logic i_trim_load,
  input wire logic i_special_mode,
  input wire logic o_periodic_timeout_flag,
  input wire logic o_temp_offset_enable,
  input wire logic [3:0] o_temp_sense_trim_bits,
  input wire logic [4:0] o_temp_threshold_steps,
  input wire logic [15:0] o_osc_trim_word,
  input wire logic [4:0] o_tempco_trim_bits,
  input wire logic o_tempco_comp_enable,
  input wire logic [3:0] o_coarse_trim,
  input wire logic [5:0] o_fine_trim,
  input wire logic [7:0] o_factory_test,
  input wire logic o_pll_locked,
  input wire logic o_osc_up
);
  localparam logic [11:0] A_OTH = {IDX_OSC_TRIM_HIGH, 2'b00};
  localparam logic [11:0] A_OTL = {IDX_OSC_TRIM_LOW, 2'b00};
  localparam logic [11:0] A_CTL = {IDX_PERIODIC_CTRL, 2'b00};
  localparam logic [11:0] A_TST = {IDX_FACTORY_TEST, 2'b00};
  logic wr_osc;
  // A write lands at the edge where waitrequest is seen low; a write without byte lane 0 is dropped
  assign wr_osc = i_avs_write && i_avs_byteenable[0] && !o_avs_waitrequest
    && (i_avs_address == A_OTH || i_avs_address == A_OTL);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  property p_bit10; o_osc_trim_word[10] == 1'b0; endproperty
  a_bit10: assert property (p_bit10) else $error("osc trim bit 10 not zero");
  property p_fields; {o_tempco_trim_bits, 1'b0, o_coarse_trim, o_fine_trim} == o_osc_trim_word; endproperty
  a_fields: assert property (p_fields) else $error("osc trim fields misplaced");
  property p_nominal;
    o_tempco_comp_enable == !(o_tempco_trim_bits == TEMPCO_NOMINAL_LOW || o_tempco_trim_bits == TEMPCO_NOMINAL_HIGH);
  endproperty
  a_nominal: assert property (p_nominal) else $error("tempco compensation wrong");
  property p_offset; !o_temp_offset_enable |-> o_temp_sense_trim_bits == 4'h0; endproperty
  a_offset: assert property (p_offset) else $error("trim bits pass while offset off");
  property p_steps; o_temp_threshold_steps == {1'b0, o_temp_sense_trim_bits}; endproperty
  a_steps: assert property (p_steps) else $error("threshold steps not binary");
  property p_protection_lock; wr_osc && i_protection_lock && !i_trim_load |=> $stable(o_osc_trim_word); endproperty
  a_protection_lock: assert property (p_protection_lock) else $error("locked osc trim changed");
  property p_clear;
    wr_osc && !i_protection_lock && i_pll_clock_select && !i_pll_lock_set && !i_osc_up_set && !i_trim_load
      |=> !o_pll_locked && !o_osc_up;
  endproperty
  a_clear: assert property (p_clear) else $error("status flags not cleared");
  property p_sticky;
    o_periodic_timeout_flag && !(i_avs_write && i_avs_address == A_CTL) |=> o_periodic_timeout_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("timeout flag dropped");
  property p_test;
    i_avs_write && !o_avs_waitrequest && i_avs_address == A_TST && !i_special_mode |=> $stable(o_factory_test);
  endproperty
  a_test: assert property (p_test) else $error("factory test written outside special mode");
endmodule // periodic_trim_chk

bind periodic_rate_and_trim_regs periodic_trim_chk u_chk (.*);

// ===== periodic_trim_pkg.sv
// Constants shared by the periodic rate and trim register block
package periodic_trim_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_PERIODIC_CTRL = 10'h2F2;
  localparam logic [9:0] IDX_RATE_HIGH = 10'h2F4;
  localparam logic [9:0] IDX_RATE_LOW = 10'h2F5;
  localparam logic [9:0] IDX_FACTORY_TEST = 10'h2F6;
  localparam logic [9:0] IDX_TEMP_SENSE_TRIM = 10'h2F7;
  localparam logic [9:0] IDX_OSC_TRIM_HIGH = 10'h2F8;
  localparam logic [9:0] IDX_OSC_TRIM_LOW = 10'h2F9;
  localparam logic [9:0] IDX_CLOCK_STATUS = 10'h300;

  // Field positions
  localparam int CTL_CLOCK_SELECT_BIT = 7;
  localparam int CTL_FEATURE_ENABLE_BIT = 2;
  localparam int CTL_TIMEOUT_FLAG_BIT = 0;
  localparam int TEMP_OFFSET_ENABLE_BIT = 7;
  localparam int TEMP_TRIM_MSB = 3;
  localparam int TEMPCO_MSB = 15;
  localparam int TEMPCO_LSB = 11;
  localparam int COARSE_MSB = 9;
  localparam int COARSE_LSB = 6;
  localparam int FINE_MSB = 5;
  localparam int STATUS_PLL_LOCKED_BIT = 0;
  localparam int STATUS_OSC_UP_BIT = 1;

  // Implemented-bit masks
  localparam logic [7:0] TEMP_TRIM_MASK = 8'h8F;
  localparam logic [15:0] OSC_TRIM_MASK = 16'hFBFF;

  // Tempco codes that switch compensation off
  localparam logic [4:0] TEMPCO_NOMINAL_LOW = 5'h00;
  localparam logic [4:0] TEMPCO_NOMINAL_HIGH = 5'h10;

  // Reset values; the temp and osc trim registers hold theirs until the flash load or an accepted bus write arrives
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Timing: bus clock ticks per rate step, and autonomous clock ticks per step
  localparam int BUS_TICKS_PER_STEP = 2;
  localparam longint ACLK_STEP_NS = 200000;
  localparam longint ACLK_NOMINAL_HZ = 20000;
  localparam int ACLK_TICKS_PER_STEP = int'((ACLK_STEP_NS * ACLK_NOMINAL_HZ) / 64'd1000000000);

endpackage

// ===== pin_sync.sv
// Three-stage synchroniser with a rising-edge pulse for an outside clock pin
`timescale 1ns/1ps
module pin_sync
  import periodic_trim_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_pin,
  output logic o_rise
);

  typedef struct packed {
    logic [2:0] stages;
    logic stable;
    logic rise;
  } sync_t;

  sync_t state;
  sync_t next_state;

  // Stage 0 is only read by stage 1; a change counts once stages 1 and 2 agree
  always_comb begin
    next_state = state;
    next_state.stages = {state.stages[1:0], i_pin};
    next_state.rise = 1'b0;
    if (state.stages[1] == state.stages[2]) begin
      next_state.stable = state.stages[2];
      next_state.rise = state.stages[2] & ~state.stable;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_rise = state.rise;

endmodule // pin_sync
